// ---- logic/qstk_defines.vh ----
// Constants of the quarter-second timekeeper: register map, fields, resets, counts.
// Assumes inclusion by bare name from the logic folder.
`ifndef QSTK_DEFINES_VH
`define QSTK_DEFINES_VH

// Byte addresses on the register bus.
`define QSTK_OFS_CTRL 4'h0
`define QSTK_OFS_STAT 4'h4
`define QSTK_OFS_MATCH 4'h8
`define QSTK_OFS_COUNT 4'hC

// Control register fields.
`define QSTK_CTRL_EN 7
`define QSTK_CTRL_SRC_HI 6
`define QSTK_CTRL_SRC_LO 5
`define QSTK_CTRL_RESTART 4
`define QSTK_CTRL_CKO_EN 3
`define QSTK_CTRL_PS_HI 2
`define QSTK_CTRL_PS_LO 0

// Status and enable register fields.
`define QSTK_STAT_QF 7
`define QSTK_STAT_SF 6
`define QSTK_STAT_MF 5
`define QSTK_STAT_QIE 4
`define QSTK_STAT_SIE 3
`define QSTK_STAT_MIE 2
`define QSTK_STAT_MEN 1
`define QSTK_STAT_PEND 0

// Reset values.
`define QSTK_RST_SRC 2'h0
`define QSTK_RST_PS 3'h1
`define QSTK_RST_MATCH 6'h00
`define QSTK_RST_COUNT 8'h00

// Reference source codes.
`define QSTK_SRC_EXT 2'h0
`define QSTK_SRC_LPO 2'h1
`define QSTK_SRC_IRC 2'h2

// Reference edges per quarter second for each divider code.
`define QSTK_DIV_000 250
`define QSTK_DIV_001 8192
`define QSTK_DIV_010 8000
`define QSTK_DIV_011 9600
`define QSTK_DIV_100 1228800
`define QSTK_DIV_101 1000000
`define QSTK_DIV_110 2000000
`define QSTK_DIV_111 4000000

// Reference edges per half period of the divided clock output, fast inputs.
`define QSTK_CKO_HALF_100 8'h40
`define QSTK_CKO_HALF_101 8'h3E
`define QSTK_CKO_HALF_110 8'h7D
`define QSTK_CKO_HALF_111 8'hFA

// Bus clock cycles during which a compare value write stays pending.
`define QSTK_PEND_CYC 3'h4

// Bus responses.
`define QSTK_RESP_OKAY 2'h0
`define QSTK_RESP_SLVERR 2'h2

`endif

// ---- logic/qstk_edge_sync.v ----
// Two-stage synchroniser for one reference clock pin with rising edge detect.
// Assumes the pin toggles slower than half the bus clock rate.
`timescale 1ns/1ns
module qstk_edge_sync (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Asynchronous pin.
  input wire pin,
  // Synchronised level and one-cycle rising edge.
  output wire level,
  output wire rise
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
endmodule

// ---- logic/qstk_timekeeper.v ----
// Quarter-second timekeeper with alarm compare, three event flags and AXI4-Lite registers.
// Assumes reference clocks arrive as asynchronous pins, all far below the bus clock.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "qstk_defines.vh"
module qstk_timekeeper #(
  parameter [22:0] DIV_000 = `QSTK_DIV_000,
  parameter [22:0] DIV_001 = `QSTK_DIV_001,
  parameter [22:0] DIV_010 = `QSTK_DIV_010,
  parameter [22:0] DIV_011 = `QSTK_DIV_011,
  parameter [22:0] DIV_100 = `QSTK_DIV_100,
  parameter [22:0] DIV_101 = `QSTK_DIV_101,
  parameter [22:0] DIV_110 = `QSTK_DIV_110,
  parameter [22:0] DIV_111 = `QSTK_DIV_111
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Write address channel.
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // Write data channel.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // Write response channel.
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read address channel.
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // Read data channel.
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Reference clock pins.
  input wire external_oscillator_clock,
  input wire low_power_oscillator,
  input wire internal_reference_clock,
  // Timekeeper outputs.
  output wire timekeeper_irq,
  output wire divided_clock_output
);
  // Control register.
  reg timekeeper_enable_ff;
  reg [1:0] reference_source_select_ff;
  reg [2:0] reference_divider_select_ff;
  reg divided_clock_output_enable_ff;
  // Status and enable register.
  reg quarter_tick_flag_ff;
  reg whole_second_flag_ff;
  reg alarm_flag_ff;
  reg quarter_tick_irq_enable_ff;
  reg whole_second_irq_enable_ff;
  reg alarm_irq_enable_ff;
  reg alarm_compare_enable_ff;
  reg alarm_write_pending_ff;
  reg [2:0] pend_cnt_ff;
  // Compare value and counter.
  reg [5:0] alarm_compare_value_ff;
  reg [1:0] match_phase_ff;
  reg [7:0] quarter_second_counter_ff;
  reg [22:0] presc_ff;
  // Clock output divider.
  reg [7:0] cko_cnt_ff;
  reg cko_ff;
  // Bus slave state.
  reg aw_held_ff;
  reg w_held_ff;
  reg [3:0] aw_addr_ff;
  reg aw_map_ff;
  reg [7:0] w_byte_ff;
  reg w_lane_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [7:0] rbyte_ff;

  // Synchronised reference clocks.
  wire ext_level;
  wire ext_rise;
  wire lpo_level;
  wire lpo_rise;
  wire irc_level;
  wire irc_rise;

  qstk_edge_sync u_sync_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(external_oscillator_clock),
    .level(ext_level),
    .rise(ext_rise)
  );

  qstk_edge_sync u_sync_lpo (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(low_power_oscillator),
    .level(lpo_level),
    .rise(lpo_rise)
  );

  qstk_edge_sync u_sync_irc (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(internal_reference_clock),
    .level(irc_level),
    .rise(irc_rise)
  );

  // Reference selection and divider lookup.
  reg ref_rise;
  reg ref_level;
  reg [22:0] div_sel;
  reg [7:0] cko_half;

  always @* begin
    case (reference_source_select_ff)
      `QSTK_SRC_EXT: begin
        ref_rise = ext_rise;
        ref_level = ext_level;
      end
      `QSTK_SRC_LPO: begin
        ref_rise = lpo_rise;
        ref_level = lpo_level;
      end
      `QSTK_SRC_IRC: begin
        ref_rise = irc_rise;
        ref_level = irc_level;
      end
      default: begin
        ref_rise = 1'b0;
        ref_level = 1'b0;
      end
    endcase
  end

  always @* begin
    cko_half = 8'h00;
    case (reference_divider_select_ff)
      3'h0: div_sel = DIV_000;
      3'h1: div_sel = DIV_001;
      3'h2: div_sel = DIV_010;
      3'h3: div_sel = DIV_011;
      3'h4: begin
        div_sel = DIV_100;
        cko_half = `QSTK_CKO_HALF_100;
      end
      3'h5: begin
        div_sel = DIV_101;
        cko_half = `QSTK_CKO_HALF_101;
      end
      3'h6: begin
        div_sel = DIV_110;
        cko_half = `QSTK_CKO_HALF_110;
      end
      default: begin
        div_sel = DIV_111;
        cko_half = `QSTK_CKO_HALF_111;
      end
    endcase
  end

  // Bus decode.
  wire aw_take = s_axi_awvalid & ~aw_held_ff & ~bvalid_ff;
  wire w_take = s_axi_wvalid & ~w_held_ff & ~bvalid_ff;
  wire wr_fire = aw_held_ff & w_held_ff;
  wire wr_ok = wr_fire & aw_map_ff & w_lane_ff;
  wire wr_ctrl = wr_ok & (aw_addr_ff == `QSTK_OFS_CTRL);
  wire wr_stat = wr_ok & (aw_addr_ff == `QSTK_OFS_STAT);
  wire wr_match = wr_ok & (aw_addr_ff == `QSTK_OFS_MATCH);
  wire ar_take = s_axi_arvalid & ~rvalid_ff;
  wire restart = wr_ctrl & w_byte_ff[`QSTK_CTRL_RESTART];

  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h000000, rbyte_ff};

  // Quarter-second tick and counter arithmetic.
  wire tick = timekeeper_enable_ff & ref_rise & (presc_ff == div_sel - 23'h000001);
  wire [7:0] cnt_inc = quarter_second_counter_ff + 8'h01;
  wire match_hit = alarm_compare_enable_ff &
    (cnt_inc == {alarm_compare_value_ff, match_phase_ff});
  wire match_ev = tick & match_hit;
  wire [7:0] nxt_counter = match_hit ? {6'h00, cnt_inc[1:0]} : cnt_inc;
  wire second_ev = tick & (cnt_inc[1:0] == 2'h0);

  // Write clears; a set in the same cycle wins.
  wire clr_qf = wr_stat & w_byte_ff[`QSTK_STAT_QF];
  wire clr_sf = wr_stat & w_byte_ff[`QSTK_STAT_SF];
  wire clr_mf = wr_stat & w_byte_ff[`QSTK_STAT_MF];

  // Control register and prescaler.
  always @(posedge aclk) begin
    if (!aresetn) begin
      timekeeper_enable_ff <= 1'b0;
      reference_source_select_ff <= `QSTK_RST_SRC;
      reference_divider_select_ff <= `QSTK_RST_PS;
      divided_clock_output_enable_ff <= 1'b0;
      presc_ff <= 23'h000000;
    end else begin
      if (wr_ctrl) begin
        timekeeper_enable_ff <= w_byte_ff[`QSTK_CTRL_EN];
        reference_source_select_ff <= w_byte_ff[`QSTK_CTRL_SRC_HI:`QSTK_CTRL_SRC_LO];
        reference_divider_select_ff <= w_byte_ff[`QSTK_CTRL_PS_HI:`QSTK_CTRL_PS_LO];
        divided_clock_output_enable_ff <= w_byte_ff[`QSTK_CTRL_CKO_EN];
      end
      if (!timekeeper_enable_ff || restart) begin
        presc_ff <= 23'h000000;
      end else if (ref_rise) begin
        presc_ff <= tick ? 23'h000000 : presc_ff + 23'h000001;
      end
    end
  end

  // Counter: held at zero while disabled, restarted on request.
  always @(posedge aclk) begin
    if (!aresetn) begin
      quarter_second_counter_ff <= `QSTK_RST_COUNT;
    end else if (!timekeeper_enable_ff || restart) begin
      quarter_second_counter_ff <= `QSTK_RST_COUNT;
    end else if (tick) begin
      quarter_second_counter_ff <= nxt_counter;
    end
  end

  // Status flags and enables.
  always @(posedge aclk) begin
    if (!aresetn) begin
      quarter_tick_flag_ff <= 1'b0;
      whole_second_flag_ff <= 1'b0;
      alarm_flag_ff <= 1'b0;
      quarter_tick_irq_enable_ff <= 1'b0;
      whole_second_irq_enable_ff <= 1'b0;
      alarm_irq_enable_ff <= 1'b0;
      alarm_compare_enable_ff <= 1'b0;
    end else begin
      quarter_tick_flag_ff <= tick | (quarter_tick_flag_ff & ~clr_qf);
      whole_second_flag_ff <= second_ev | (whole_second_flag_ff & ~clr_sf);
      alarm_flag_ff <= match_ev | (alarm_flag_ff & ~clr_mf);
      if (wr_stat) begin
        quarter_tick_irq_enable_ff <= w_byte_ff[`QSTK_STAT_QIE];
        whole_second_irq_enable_ff <= w_byte_ff[`QSTK_STAT_SIE];
        alarm_irq_enable_ff <= w_byte_ff[`QSTK_STAT_MIE];
        alarm_compare_enable_ff <= w_byte_ff[`QSTK_STAT_MEN];
      end
    end
  end

  // Compare value; the low two bits take the counter phase at the write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      alarm_compare_value_ff <= `QSTK_RST_MATCH;
      match_phase_ff <= 2'h0;
      alarm_write_pending_ff <= 1'b0;
      pend_cnt_ff <= 3'h0;
    end else if (wr_match && !alarm_write_pending_ff) begin
      alarm_compare_value_ff <= w_byte_ff[7:2];
      match_phase_ff <= quarter_second_counter_ff[1:0];
      alarm_write_pending_ff <= 1'b1;
      pend_cnt_ff <= `QSTK_PEND_CYC - 3'h1;
    end else if (alarm_write_pending_ff) begin
      // A write in this state is dropped.
      pend_cnt_ff <= pend_cnt_ff - 3'h1;
      if (pend_cnt_ff == 3'h0) begin
        alarm_write_pending_ff <= 1'b0;
      end
    end
  end

  // One interrupt line for all three events.
  assign timekeeper_irq = (quarter_tick_flag_ff & quarter_tick_irq_enable_ff) |
    (whole_second_flag_ff & whole_second_irq_enable_ff) |
    (alarm_flag_ff & alarm_irq_enable_ff);

  // Divided clock output: held low for divider code 000, other slow inputs pass through, fast ones are divided down.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cko_cnt_ff <= 8'h00;
      cko_ff <= 1'b0;
    end else if (!timekeeper_enable_ff || !divided_clock_output_enable_ff ||
                 reference_divider_select_ff == 3'h0) begin
      cko_cnt_ff <= 8'h00;
      cko_ff <= 1'b0;
    end else if (cko_half == 8'h00) begin
      cko_ff <= ref_level;
    end else if (ref_rise) begin
      if (cko_cnt_ff == cko_half - 8'h01) begin
        cko_cnt_ff <= 8'h00;
        cko_ff <= ~cko_ff;
      end else begin
        cko_cnt_ff <= cko_cnt_ff + 8'h01;
      end
    end
  end

  assign divided_clock_output = cko_ff;

  // Write channel: address and data captured in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      aw_map_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `QSTK_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[3:0];
        aw_map_ff <= (s_axi_awaddr[31:4] == 28'h0000000) &&
          (s_axi_awaddr[1:0] == 2'h0);
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= aw_map_ff ? `QSTK_RESP_OKAY : `QSTK_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address.
  reg [7:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_hit = (s_axi_araddr[31:4] == 28'h0000000) && (s_axi_araddr[1:0] == 2'h0);
    case (s_axi_araddr[3:0])
      `QSTK_OFS_CTRL: rd_mux = {timekeeper_enable_ff, reference_source_select_ff, 1'b0,
        divided_clock_output_enable_ff, reference_divider_select_ff};
      `QSTK_OFS_STAT: rd_mux = {quarter_tick_flag_ff, whole_second_flag_ff, alarm_flag_ff,
        quarter_tick_irq_enable_ff, whole_second_irq_enable_ff, alarm_irq_enable_ff,
        alarm_compare_enable_ff, alarm_write_pending_ff};
      `QSTK_OFS_MATCH: rd_mux = {alarm_compare_value_ff, match_phase_ff};
      `QSTK_OFS_COUNT: rd_mux = quarter_second_counter_ff;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `QSTK_RESP_OKAY;
      rbyte_ff <= 8'h00;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? `QSTK_RESP_OKAY : `QSTK_RESP_SLVERR;
      rbyte_ff <= rd_hit ? rd_mux : 8'h00;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// ---- verification/qstk_timekeeper_properties.sv ----
// Checker of the timekeeper read path, reset values and interrupt output.
// Assumes it is bound to qstk_timekeeper and sees only that module's ports.
`timescale 1ns/1ns
`include "qstk_defines.vh"
module qstk_timekeeper_chk (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Register bus.
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  // Interrupt.
  input wire timekeeper_irq
);
  reg [31:0] raddr_ff;
  reg no_wr_ff;
  // Tracks the read address and whether any write has completed since reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      raddr_ff <= 32'h00000000;
      no_wr_ff <= 1'b1;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        raddr_ff <= s_axi_araddr;
      end
      if (s_axi_bvalid) begin
        no_wr_ff <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_ctrl;
    $rose(s_axi_rvalid) && no_wr_ff && raddr_ff == 32'h0 |-> s_axi_rdata == 32'h1;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl)
    else $error("control reset value wrong");
  property p_rst_stat;
    $rose(s_axi_rvalid) && no_wr_ff && raddr_ff == 32'h4 |-> s_axi_rdata == 32'h0;
  endproperty
  a_rst_stat: assert property (p_rst_stat)
    else $error("status reset value wrong");
  property p_rst_regs;
    $rose(s_axi_rvalid) && no_wr_ff && raddr_ff[31:3] == 29'h1 |-> s_axi_rdata == 32'h0;
  endproperty
  a_rst_regs: assert property (p_rst_regs)
    else $error("compare or counter reset value wrong");
  property p_irq_fall;
    $fell(timekeeper_irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  property p_irq_stat;
    $rose(s_axi_rvalid) && raddr_ff == 32'h4 && (|(s_axi_rdata[7:5] & s_axi_rdata[4:2]))
      |-> timekeeper_irq;
  endproperty
  a_irq_stat: assert property (p_irq_stat)
    else $error("interrupt low with an enabled flag set");
  property p_restart0;
    $rose(s_axi_rvalid) && raddr_ff == 32'h0 |-> !s_axi_rdata[4];
  endproperty
  a_restart0: assert property (p_restart0)
    else $error("restart bit reads one");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'hF
      |=> s_axi_rresp == `QSTK_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data not held");
endmodule
bind qstk_timekeeper qstk_timekeeper_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .timekeeper_irq(timekeeper_irq));

// ---- verification/test_qstk_timekeeper.sv ----
// Self-checking bench of the quarter-second timekeeper through its register bus.
// Assumes shortened dividers; the checker is bound in from its own file.
`timescale 1ns/1ns
`include "qstk_defines.vh"
module test_qstk_timekeeper;
  localparam [7:0] A_CTL = {4'h0, `QSTK_OFS_CTRL};
  localparam [7:0] A_STA = {4'h0, `QSTK_OFS_STAT};
  localparam [7:0] A_CMP = {4'h0, `QSTK_OFS_MATCH};
  localparam [7:0] A_CNT = {4'h0, `QSTK_OFS_COUNT};
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [31:0] s_axi_awaddr = 32'h0;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [31:0] s_axi_araddr = 32'h0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg [4:0] ref_cnt = 5'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire timekeeper_irq;
  wire divided_clock_output;
  reg [7:0] rd_data;
  reg [1:0] rd_resp;
  reg [1:0] wr_resp;
  integer rd_lag = 0;
  integer err_count = 0;
  integer checked = 0;
  integer cyc = 0;
  qstk_timekeeper #(.DIV_000(23'h4), .DIV_001(23'h4), .DIV_011(23'h4)) dut (.aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .external_oscillator_clock(ref_cnt[2]),
    .low_power_oscillator(ref_cnt[3]), .internal_reference_clock(ref_cnt[4]),
    .timekeeper_irq(timekeeper_irq), .divided_clock_output(divided_clock_output));
  always #2 aclk = ~aclk;
  // The external pin has a period of 8 bus cycles, the low-power one 16, the internal one 32.
  always @(posedge aclk) begin
    ref_cnt <= ref_cnt + 5'h01;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      if (err_count == 0 && checked > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        $display("Error %s expected %h seen %h", nm, e, g);
        err_count = err_count + 1;
      end
    end
  endtask
  // Bus tasks are entered just after a clock edge.
  task wr(input [7:0] a, input [7:0] d);
    reg aw;
    reg w;
    begin
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
        @(posedge aclk);
        aw = aw | s_axi_awready;
        w = w | s_axi_wready;
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (rd_lag == 0);
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      // A late ready makes the slave hold its read answer for a while.
      if (rd_lag != 0) begin
        repeat (rd_lag) @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
      end
      while (!s_axi_rvalid) @(posedge aclk);
      rd_data = s_axi_rdata[7:0];
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task wait_set(input [7:0] m);
    integer n;
    begin
      n = 0;
      rd(A_STA);
      while ((rd_data & m) == 8'h00 && n < 200) begin
        rd(A_STA);
        n = n + 1;
      end
      chk("status flag", m, rd_data & m);
    end
  endtask
  task t_reset;
    begin
      rd_lag = 3;
      rd(A_CTL);
      rd_lag = 0;
      chk("control", 8'h01, rd_data);
      rd(A_STA);
      chk("status", 8'h00, rd_data);
      rd(A_CMP);
      chk("compare", 8'h00, rd_data);
      rd(A_CNT);
      chk("counter", 8'h00, rd_data);
      rd(8'h10);
      chk("unmapped resp", {6'h0, `QSTK_RESP_SLVERR}, {6'h0, rd_resp});
      // A write without its low byte lane is answered but changes nothing.
      s_axi_wstrb <= 4'h0;
      wr(A_STA, 8'hFF);
      chk("strobe resp", {6'h0, `QSTK_RESP_OKAY}, {6'h0, wr_resp});
      s_axi_wstrb <= 4'hF;
      rd(A_STA);
      chk("status", 8'h00, rd_data);
    end
  endtask
  task t_quarter;
    begin
      wr(A_STA, 8'h10);
      wr(A_CTL, 8'h81);
      wait_set(8'h80);
      chk("irq", 8'h01, {7'h0, timekeeper_irq});
      rd(A_CNT);
      chk("counter", 8'h01, rd_data);
      wr(A_STA, 8'h90);
      rd(A_STA);
      chk("status", 8'h10, rd_data);
      chk("irq", 8'h00, {7'h0, timekeeper_irq});
    end
  endtask
  task t_second;
    begin
      wr(A_STA, 8'h08);
      wait_set(8'h40);
      rd(A_CNT);
      chk("counter low bits", 8'h00, rd_data & 8'h03);
      rd(A_STA);
      chk("status", 8'hC8, rd_data);
      chk("irq", 8'h01, {7'h0, timekeeper_irq});
      wr(A_STA, 8'h48);
      rd(A_STA);
      chk("status", 8'h88, rd_data);
      chk("irq", 8'h00, {7'h0, timekeeper_irq});
    end
  endtask
  task t_match;
    begin
      wr(A_STA, 8'hE0);
      wr(A_CTL, 8'h91);
      rd(A_CNT);
      chk("counter", 8'h00, rd_data);
      rd(A_CTL);
      chk("control", 8'h81, rd_data);
      // Two seconds past the current upper six bits, which are zero.
      wr(A_CMP, 8'h08);
      wr(A_CMP, 8'hFC);
      rd(A_CMP);
      chk("compare", 8'h08, rd_data);
      wr(A_STA, 8'h06);
      wait_set(8'h20);
      chk("irq", 8'h01, {7'h0, timekeeper_irq});
      rd(A_CNT);
      chk("counter", 8'h00, rd_data);
      wr(A_STA, 8'h86);
      wait_set(8'h80);
      rd(A_STA);
      chk("alarm flag", 8'h20, rd_data & 8'h20);
      chk("irq", 8'h01, {7'h0, timekeeper_irq});
      wr(A_STA, 8'h26);
      rd(A_STA);
      chk("alarm flag", 8'h00, rd_data & 8'h20);
      chk("irq", 8'h00, {7'h0, timekeeper_irq});
    end
  endtask
  task t_quiet_match;
    begin
      wr(A_CTL, 8'h91);
      wr(A_CMP, 8'h04);
      wr(A_STA, 8'h02);
      wait_set(8'h20);
      chk("irq", 8'h00, {7'h0, timekeeper_irq});
      rd(A_CNT);
      chk("counter high bits", 8'h00, rd_data & 8'hFC);
      wr(A_STA, 8'hE2);
      wr(A_CTL, 8'h01);
      repeat (100) @(posedge aclk);
      rd(A_STA);
      chk("status", 8'h02, rd_data);
      rd(A_CNT);
      chk("counter", 8'h00, rd_data);
    end
  endtask
  task t_internal;
    reg cko_seen;
    begin
      cko_seen = 1'b0;
      wr(A_CTL, 8'h43);
      wr(A_CTL, 8'hC3);
      // The external pin would have ticked by now, the internal one not yet.
      repeat (60) begin
        @(posedge aclk);
        cko_seen = cko_seen | divided_clock_output;
      end
      chk("clock out", 8'h00, {7'h0, cko_seen});
      rd(A_CNT);
      chk("counter", 8'h00, rd_data);
      wait_set(8'h80);
      rd(A_CNT);
      chk("counter", 8'h01, rd_data);
      // With its enable set, the clock output follows the internal reference.
      wr(A_CTL, 8'hCB);
      cko_seen = 1'b0;
      repeat (40) begin
        @(posedge aclk);
        cko_seen = cko_seen | divided_clock_output;
      end
      chk("clock out", 8'h01, {7'h0, cko_seen});
      // Low-power source, restarted, then the flags cleared before its first tick.
      wr(A_CTL, 8'hB0);
      wr(A_STA, 8'hE0);
      wait_set(8'h80);
      rd(A_CNT);
      chk("counter", 8'h01, rd_data);
    end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_quarter;
    t_second;
    t_match;
    t_quiet_match;
    t_internal;
    tally_and_finish;
  end
endmodule
